// File: cmb_defs.vh
// constants for the can message buffer and acceptance filter block
`ifndef CMB_DEFS_VH
`define CMB_DEFS_VH
`define CMB_OFS_CTRL      8'h00
`define CMB_OFS_RXFLAG    8'h04
`define CMB_OFS_TXFLAG    8'h08
`define CMB_OFS_TXCTRL    8'h0C
`define CMB_OFS_PATTERN   8'h10
`define CMB_OFS_MASK      8'h14
`define CMB_OFS_FOREGROUND_RX_BUFFER      8'h40
`define CMB_OFS_TXBUF     8'h50
`define CMB_TXBUF_STRIDE  8'h10
`define CMB_BUF_BYTES     13
`define CMB_LOCAL_PRIORITY_FIELD_BYTE     4'hD
`define CMB_IDE_BIT       3
`define CMB_MODE_SINGLE   2'h0
`define CMB_MODE_DUAL     2'h1
`define CMB_MODE_QUAD     2'h2
`define CMB_MODE_CLOSED   2'h3
`define CMB_RXF_BIT       0
`define CMB_OVR_BIT       1
`define CMB_HIT_LSB       2
`define CMB_LOOP_BIT      2
`define CMB_ABORT_ACKNOWLEDGE_BIT_LSB     4
`define CMB_TXE_RESET     3'h7
`define CMB_RECESSIVE     1'b1
`endif

// File: cmb_core.v
// can message buffers, transmit scheduling and identifier acceptance filter
`timescale 1ns/1ps
`default_nettype none
`include "cmb_defs.vh"
// Notes on behaviour
// - transmit pin shows bus level, 0 dominant, 1 recessive
// - two-stage receive fifo, only foreground visible to software
// - each receive buffer stores 13 bytes: id, control, data
// - receive-full set when foreground holds an accepted good frame
// - every frame lands in background unless an accepted frame is pending there, filter runs alongside
// - copy background to foreground only while receive-full clear, then set it
// - own frames stay in background, no flag, no bus acknowledge
// - loop-back treats own frames like any received frame
// - lost arbitration turns the node into receiver of the winner
// - both buffers full plus new accepted frame: drop it, flag overrun
// - three transmit buffers of 13 bytes, each with 8-bit priority
// - successful send sets transmit-empty for that buffer
// - every arbitration picks ready buffer with lowest priority value
// - abort granted only if not on the bus; sets ack and empty
// - abort ack reads 1 after abort, 0 after real transmission
// - four pattern bytes and four mask bytes, mask 1 ignores bit
// - two-bit hit indicator reports lowest matching filter section
// - single mode: one 32-bit filter over extended or standard id
// - dual mode: two 16-bit filters over the top identifier bits
// - quad mode: four 8-bit filters; closed mode accepts nothing
// - flags clear by writing 1, no effect while condition holds
module cmb_core (
  input  wire        ref_clk_in,
  input  wire        rst_b_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output wire        wb_ack_out,
  input  wire        bus_receive_pin_in,
  output reg         bus_transmit_pin_out,
  output reg         rx_bit_out,
  input  wire        eng_tx_bit_in,
  input  wire        rx_wr_in,
  input  wire [3:0]  rx_idx_in,
  input  wire [7:0]  rx_data_in,
  input  wire        rx_frame_ok_in,
  input  wire        tx_start_in,
  input  wire        tx_done_in,
  input  wire        tx_err_in,
  input  wire        arb_lost_in,
  input  wire [3:0]  tx_rd_idx_in,
  output wire        tx_valid_out,
  output wire [1:0]  tx_buf_out,
  output reg  [7:0]  tx_rd_data_out,
  output wire        loopback_out,
  output wire        ack_enable_out
);

  reg  [7:0]  bg_mem [0:12];
  reg  [7:0]  fg_mem [0:12];
  reg  [7:0]  tx_mem [0:47];
  reg  [31:0] pattern_q;
  reg  [31:0] mask_q;
  reg  [1:0]  mode_q;
  reg         loop_q;
  reg         rxf_q;
  reg         ovr_q;
  reg         bg_pend_q;
  reg  [1:0]  bg_hit_q;
  reg  [1:0]  fg_hit_q;
  reg  [2:0]  txe_q;
  reg  [2:0]  abort_request_bit_q;
  reg  [2:0]  abort_acknowledge_bit_q;
  reg         tx_act_q;
  reg  [1:0]  tx_cur_q;
  reg         ack_q;
  reg         sync1_q;
  reg         sync2_q;
  reg         sync3_q;
  integer     i;
  integer     s;
  integer     t;

  assign wb_ack_out     = ack_q;
  assign loopback_out   = loop_q;
  assign ack_enable_out = ~(tx_act_q & ~loop_q);

  function byte_hit;
    input [7:0] id;
    input [7:0] ar;
    input [7:0] mr;
    begin
      byte_hit = (((id ^ ar) & ~mr) == 8'h00);
    end
  endfunction

  // filter over the background identifier bytes
  wire [7:0] id0 = bg_mem[0];
  wire [7:0] id1 = bg_mem[1];
  wire [7:0] id2 = bg_mem[2];
  wire [7:0] id3 = bg_mem[3];
  wire       ext = id1[`CMB_IDE_BIT];
  wire m0 = byte_hit(id0, pattern_q[7:0],   mask_q[7:0]);
  wire m1 = byte_hit(id1, pattern_q[15:8],  mask_q[15:8]);
  wire m2 = byte_hit(id2, pattern_q[23:16], mask_q[23:16]);
  wire m3 = byte_hit(id3, pattern_q[31:24], mask_q[31:24]);
  wire d1a = byte_hit(id0, pattern_q[23:16], mask_q[23:16]);
  wire d1b = byte_hit(id1, pattern_q[31:24], mask_q[31:24]);
  wire q1 = byte_hit(id0, pattern_q[15:8],  mask_q[15:8]);
  wire q2 = byte_hit(id0, pattern_q[23:16], mask_q[23:16]);
  wire q3 = byte_hit(id0, pattern_q[31:24], mask_q[31:24]);
  reg  [3:0] hits;
  reg        acc;
  reg  [1:0] hit_idx;

  always @* begin
    hits = 4'h0;
    case (mode_q)
      `CMB_MODE_SINGLE: hits = {3'h0, m0 & m1 & (~ext | (m2 & m3))};
      `CMB_MODE_DUAL:   hits = {2'h0, d1a & d1b, m0 & m1};
      `CMB_MODE_QUAD:   hits = {q3, q2, q1, m0};
      default:          hits = 4'h0;
    endcase
    acc = |hits;
    if (hits[0]) begin
      hit_idx = 2'h0;
    end else if (hits[1]) begin
      hit_idx = 2'h1;
    end else if (hits[2]) begin
      hit_idx = 2'h2;
    end else begin
      hit_idx = 2'h3;
    end
  end

  // transmit buffer selection, lowest priority value wins
  reg        sel_ok;
  reg  [1:0] sel_idx;
  reg  [7:0] sel_local_priority_field;
  always @* begin
    sel_ok   = 1'b0;
    sel_idx  = 2'h0;
    sel_local_priority_field = 8'hFF;
    // strict compare: ties go to the lower buffer index
    for (s = 0; s < 3; s = s + 1) begin
      if (!txe_q[s] && (!sel_ok || tx_mem[s*16+13] < sel_local_priority_field)) begin
        sel_ok   = 1'b1;
        sel_idx  = s[1:0];
        sel_local_priority_field = tx_mem[s*16+13];
      end
    end
  end
  assign tx_valid_out = sel_ok & ~tx_act_q;
  assign tx_buf_out   = sel_idx;

  // single-lane register strobe; every control field sits in byte lane 0
  function lane0_wr;
    input       wr;
    input [7:0] adr;
    input       sel0;
    input [7:0] ofs;
    begin
      lane0_wr = wr && (adr == ofs) && sel0;
    end
  endfunction

  // bus decode
  wire        wb_req  = wb_cyc_in & wb_stb_in;
  wire        wb_wr   = wb_req & wb_we_in & ack_q;
  wire [7:0]  tx_off  = wb_adr_in - `CMB_OFS_TXBUF;
  wire        in_tx   = (wb_adr_in >= `CMB_OFS_TXBUF) && (tx_off < 8'h30);
  wire [1:0]  tx_n    = tx_off[5:4];
  wire        in_fg   = (wb_adr_in >= `CMB_OFS_FOREGROUND_RX_BUFFER) && (wb_adr_in < `CMB_OFS_TXBUF);
  wire [3:0]  word_b  = {wb_adr_in[3:2], 2'b00};
  wire [2:0]  wr_txe  = lane0_wr(wb_wr, wb_adr_in, wb_sel_in[0], `CMB_OFS_TXFLAG)
                        ? wb_dat_in[2:0] : 3'h0;
  wire [2:0]  wr_abt  = lane0_wr(wb_wr, wb_adr_in, wb_sel_in[0], `CMB_OFS_TXCTRL)
                        ? wb_dat_in[2:0] : 3'h0;
  wire        clr_rxf = lane0_wr(wb_wr, wb_adr_in, wb_sel_in[0], `CMB_OFS_RXFLAG)
                        && wb_dat_in[`CMB_RXF_BIT];
  wire        clr_ovr = lane0_wr(wb_wr, wb_adr_in, wb_sel_in[0], `CMB_OFS_RXFLAG)
                        && wb_dat_in[`CMB_OVR_BIT];

  function [7:0] mem_byte;
    input [3:0] b;
    input       fg;
    input [1:0] n;
    begin
      if (fg) begin
        mem_byte = (b < 4'hD) ? fg_mem[b] : 8'h00;
      end else begin
        mem_byte = (b <= `CMB_LOCAL_PRIORITY_FIELD_BYTE) ? tx_mem[{n, b}] : 8'h00;
      end
    end
  endfunction

  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    if (wb_adr_in == `CMB_OFS_CTRL) begin
      rd_d = {29'h0, loop_q, mode_q};
    end else if (wb_adr_in == `CMB_OFS_RXFLAG) begin
      rd_d = {28'h0, fg_hit_q, ovr_q, rxf_q};
    end else if (wb_adr_in == `CMB_OFS_TXFLAG) begin
      rd_d = {29'h0, txe_q};
    end else if (wb_adr_in == `CMB_OFS_TXCTRL) begin
      rd_d = {25'h0, abort_acknowledge_bit_q, 1'b0, abort_request_bit_q};
    end else if (wb_adr_in == `CMB_OFS_PATTERN) begin
      rd_d = pattern_q;
    end else if (wb_adr_in == `CMB_OFS_MASK) begin
      rd_d = mask_q;
    end else if (in_fg || in_tx) begin
      rd_d = {mem_byte(word_b + 4'h3, in_fg, tx_n), mem_byte(word_b + 4'h2, in_fg, tx_n),
              mem_byte(word_b + 4'h1, in_fg, tx_n), mem_byte(word_b, in_fg, tx_n)};
    end
  end

  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_q      <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req & ~ack_q;
      if (wb_req && !ack_q) begin
        wb_dat_out <= rd_d;
      end
    end
  end

  // pin side: sync the receive pin, register the transmit pin
  // chain resets recessive so no false edge follows reset
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_q              <= `CMB_RECESSIVE;
      sync2_q              <= `CMB_RECESSIVE;
      sync3_q              <= `CMB_RECESSIVE;
      rx_bit_out           <= `CMB_RECESSIVE;
      bus_transmit_pin_out <= `CMB_RECESSIVE;
    end else begin
      sync1_q <= bus_receive_pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        rx_bit_out <= sync3_q;
      end
      bus_transmit_pin_out <= eng_tx_bit_in;
    end
  end

  // configuration and buffer storage
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_q    <= `CMB_MODE_SINGLE;
      loop_q    <= 1'b0;
      pattern_q <= 32'h0000_0000;
      mask_q    <= 32'h0000_0000;
      for (i = 0; i < 13; i = i + 1) begin
        bg_mem[i] <= 8'h00;
        fg_mem[i] <= 8'h00;
      end
      for (i = 0; i < 48; i = i + 1) begin
        tx_mem[i] <= 8'h00;
      end
    end else begin
      if (lane0_wr(wb_wr, wb_adr_in, wb_sel_in[0], `CMB_OFS_CTRL)) begin
        mode_q <= wb_dat_in[1:0];
        loop_q <= wb_dat_in[`CMB_LOOP_BIT];
      end
      for (i = 0; i < 4; i = i + 1) begin
        if (wb_wr && wb_sel_in[i] && wb_adr_in == `CMB_OFS_PATTERN) begin
          pattern_q[i*8 +: 8] <= wb_dat_in[i*8 +: 8];
        end
        if (wb_wr && wb_sel_in[i] && wb_adr_in == `CMB_OFS_MASK) begin
          mask_q[i*8 +: 8] <= wb_dat_in[i*8 +: 8];
        end
        // a buffer handed to the scheduler is write protected
        if (wb_wr && wb_sel_in[i] && in_tx && txe_q[tx_n]
            && (word_b + i[3:0]) <= `CMB_LOCAL_PRIORITY_FIELD_BYTE) begin
          tx_mem[{tx_n, word_b + i[3:0]}] <= wb_dat_in[i*8 +: 8];
        end
      end
      // a pending accepted frame is never overwritten by the next one
      if (rx_wr_in && !bg_pend_q && rx_idx_in < 4'hD) begin
        bg_mem[rx_idx_in] <= rx_data_in;
      end
      if (bg_pend_q && !rxf_q) begin
        for (i = 0; i < 13; i = i + 1) begin
          fg_mem[i] <= bg_mem[i];
        end
      end
    end
  end

  // receive flags and background occupancy
  // own frames still fill the background buffer, only the copy is held back
  wire own_frame = tx_act_q & ~loop_q;
  wire take      = rx_frame_ok_in & acc & ~own_frame;
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rxf_q     <= 1'b0;
      ovr_q     <= 1'b0;
      bg_pend_q <= 1'b0;
      bg_hit_q  <= 2'h0;
      fg_hit_q  <= 2'h0;
    end else begin
      // hit field keeps the last accepted section until the next copy
      if (bg_pend_q && !rxf_q) begin
        rxf_q     <= 1'b1;
        fg_hit_q  <= bg_hit_q;
        bg_pend_q <= 1'b0;
      end else if (clr_rxf) begin
        rxf_q <= 1'b0;
      end
      if (take && !bg_pend_q) begin
        bg_pend_q <= 1'b1;
        bg_hit_q  <= hit_idx;
      end
      // set wins over a clear landing in the same cycle
      if (take && bg_pend_q && rxf_q) begin
        ovr_q <= 1'b1;
      end else if (clr_ovr) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // transmit scheduling, completion and abort
  always @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      txe_q    <= `CMB_TXE_RESET;
      abort_request_bit_q  <= 3'h0;
      abort_acknowledge_bit_q  <= 3'h0;
      tx_act_q <= 1'b0;
      tx_cur_q <= 2'h0;
      tx_rd_data_out <= 8'h00;
    end else begin
      tx_rd_data_out <= (tx_rd_idx_in <= `CMB_LOCAL_PRIORITY_FIELD_BYTE) ? tx_mem[{tx_cur_q, tx_rd_idx_in}]
                                                         : 8'h00;
      // error or lost arbitration leaves the buffer ready for a fresh choice
      if (tx_start_in && tx_valid_out) begin
        tx_act_q <= 1'b1;
        tx_cur_q <= sel_idx;
      end else if (tx_done_in || tx_err_in || arb_lost_in) begin
        tx_act_q <= 1'b0;
      end
      for (t = 0; t < 3; t = t + 1) begin
        if (tx_done_in && tx_act_q && tx_cur_q == t[1:0]) begin
          txe_q[t]   <= 1'b1;
          abort_acknowledge_bit_q[t] <= 1'b0;
          abort_request_bit_q[t] <= 1'b0;
        // the frame on the bus cannot be aborted, only queued ones
        end else if (abort_request_bit_q[t] && !txe_q[t] && !(tx_act_q && tx_cur_q == t[1:0])) begin
          txe_q[t]   <= 1'b1;
          abort_acknowledge_bit_q[t] <= 1'b1;
          abort_request_bit_q[t] <= 1'b0;
        end else begin
          if (wr_txe[t] && txe_q[t]) begin
            txe_q[t]   <= 1'b0;
            abort_acknowledge_bit_q[t] <= 1'b0;
          end
          if (wr_abt[t] && !txe_q[t]) begin
            abort_request_bit_q[t] <= 1'b1;
          end
        end
      end
    end
  end

endmodule // cmb_core
`default_nettype wire

// File: cmb_core_props.sv
// concurrent checks on the ports of the can message buffer block
`timescale 1ns/1ps
`default_nettype none
module cmb_core_props (
  input wire logic        ref_clk_in,
  input wire logic        rst_b_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        bus_receive_pin_in,
  input wire logic        bus_transmit_pin_out,
  input wire logic        rx_bit_out,
  input wire logic        eng_tx_bit_in,
  input wire logic        tx_start_in,
  input wire logic        tx_done_in,
  input wire logic        tx_err_in,
  input wire logic        arb_lost_in,
  input wire logic        tx_valid_out,
  input wire logic [1:0]  tx_buf_out,
  input wire logic        loopback_out,
  input wire logic        ack_enable_out
);
  logic own_q;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  // own frame on the bus: start taken, no end seen yet
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
    if (!rst_b_in) own_q <= 1'b0;
    else if (tx_done_in || tx_err_in || arb_lost_in) own_q <= 1'b0;
    else if (tx_start_in && tx_valid_out) own_q <= 1'b1;
  tx_pin_a: assert property ($past(rst_b_in) |-> bus_transmit_pin_out == $past(eng_tx_bit_in))
    else $error("transmit pin does not follow engine bit");
  rx_sync_a: assert property (($stable(bus_receive_pin_in) && $past(rst_b_in, 5))[*5]
    |-> rx_bit_out == bus_receive_pin_in) else $error("receive bit not settled");
  ack_once_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_resp_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("bus request not acked next cycle");
  dat_hold_a: assert property ($changed(wb_dat_out) |-> wb_ack_out)
    else $error("read data moved outside an access");
  loop_set_a: assert property ($changed(loopback_out) |-> $past(wb_ack_out && wb_we_in))
    else $error("loop-back bit moved without a write");
  own_ack_a: assert property (own_q |-> ack_enable_out == loopback_out)
    else $error("own frame acknowledge wrong");
  arb_rx_a: assert property (own_q && arb_lost_in |=> ack_enable_out)
    else $error("not receiver after lost arbitration");
  valid_buf_a: assert property (tx_valid_out |-> !own_q && tx_buf_out != 2'h3)
    else $error("transmit offer while busy or bad buffer");
  cover property (own_q && !loopback_out);
  cover property (own_q && loopback_out);
  cover property (own_q && arb_lost_in);
endmodule // cmb_core_props
bind cmb_core cmb_core_props u_props (.*);
`default_nettype wire

// File: cmb_node_model.sv
// behavioural protocol engine and remote node beside the block
`timescale 1ns/1ps
`default_nettype none
module cmb_node_model (
  input  wire logic       clk_in,
  input  wire logic       tx_pin_in,
  output wire logic       rx_pin_out,
  output var  logic       eng_bit_out,
  output var  logic       rx_wr_out,
  output var  logic [3:0] rx_idx_out,
  output var  logic [7:0] rx_data_out,
  output var  logic       frame_ok_out,
  output var  logic [3:0] ctl_out
);
  logic other_q = 1'b1;
  // wired bus: a dominant 0 from either node wins
  assign rx_pin_out = tx_pin_in & other_q;
  initial {eng_bit_out, rx_wr_out, rx_idx_out, rx_data_out, frame_ok_out, ctl_out} = '0;
  // idle is recessive so the receive line rests between frames
  always @(posedge clk_in) begin
    eng_bit_out <= rx_wr_out ? rx_data_out[1] : 1'b1;
    other_q     <= rx_wr_out ? rx_data_out[0] : 1'b1;
  end
  // no gap after end of frame: next call may follow at once
  task automatic frame(input logic [31:0] id, input logic [7:0] base);
    for (int i = 0; i < 13; i++) begin
      @(posedge clk_in);
      rx_wr_out   <= 1'b1;
      rx_idx_out  <= i[3:0];
      rx_data_out <= (i < 4) ? id[8*i +: 8] : base + i[7:0];
    end
    @(posedge clk_in);
    rx_wr_out    <= 1'b0;
    frame_ok_out <= 1'b1;
    @(posedge clk_in);
    frame_ok_out <= 1'b0;
  endtask
  // one-cycle pulse: start, done, error, lost
  task automatic pulse(input logic [3:0] which);
    @(posedge clk_in);
    ctl_out <= which;
    @(posedge clk_in);
    ctl_out <= 4'h0;
  endtask
endmodule // cmb_node_model
`default_nettype wire

// File: cmb_core_tb.sv
// self-checking bench for the can message buffer block
`timescale 1ns/1ps
`default_nettype none
`include "cmb_defs.vh"
module cmb_core_tb;
  localparam logic [31:0] ID0 = 32'h4433_0811;
  // filter cases: mode, pattern, mask, frame id, expected receive flags
  function automatic logic [101:0] flt(input int k);
    case (k)
      0: flt = {`CMB_MODE_SINGLE, ID0, 32'h0, ID0, 4'h1};
      1: flt = {`CMB_MODE_SINGLE, 32'h4433_0810, 32'h0, ID0, 4'h0};
      2: flt = {`CMB_MODE_SINGLE, 32'h4433_0810, 32'h1, ID0, 4'h1};
      3: flt = {`CMB_MODE_SINGLE, 32'h0000_0011, 32'h0, 32'hFFFF_0011, 4'h1};
      4: flt = {`CMB_MODE_DUAL, 32'h0811_0000, 32'h0, ID0, 4'h5};
      5: flt = {`CMB_MODE_QUAD, 32'h1111_0000, 32'h0, ID0, 4'h9};
      // closed: nothing lands, hit field still shows the previous section
      default: flt = {`CMB_MODE_CLOSED, ID0, 32'h0, ID0, 4'h8};
    endcase
  endfunction
  logic        clk, rst_b, cyc, stb, we, ack, tx_pin, rx_pin, eng_bit, rx_wr, frame_ok;
  logic        rx_bit, tx_valid, loop_out, ack_en;
  logic [7:0]  adr, rx_data, rd_byte;
  logic [3:0]  rx_idx, rd_idx, ctl, ex, sel;
  logic [1:0]  buf_sel, m;
  logic [31:0] wdat, rdat, dout, pat, msk, fid;
  int          fails = 0, checks_done = 0, cycles = 0;
  cmb_core dut (.ref_clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dout),
    .wb_ack_out(ack), .bus_receive_pin_in(rx_pin), .bus_transmit_pin_out(tx_pin),
    .rx_bit_out(rx_bit), .eng_tx_bit_in(eng_bit), .rx_wr_in(rx_wr), .rx_idx_in(rx_idx),
    .rx_data_in(rx_data), .rx_frame_ok_in(frame_ok), .tx_start_in(ctl[3]),
    .tx_done_in(ctl[2]), .tx_err_in(ctl[1]), .arb_lost_in(ctl[0]), .tx_rd_idx_in(rd_idx),
    .tx_valid_out(tx_valid), .tx_buf_out(buf_sel), .tx_rd_data_out(rd_byte),
    .loopback_out(loop_out), .ack_enable_out(ack_en));
  cmb_node_model node (.clk_in(clk), .tx_pin_in(tx_pin), .rx_pin_out(rx_pin),
    .eng_bit_out(eng_bit), .rx_wr_out(rx_wr), .rx_idx_out(rx_idx), .rx_data_out(rx_data),
    .frame_ok_out(frame_ok), .ctl_out(ctl));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // request held until ack is seen high at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= 4'hF;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  initial begin
    {cyc, stb, we, sel, adr, wdat, rd_idx} = '0;
    rst_b = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(`CMB_OFS_TXFLAG, 32'h7);
    rd(8'hFC, 32'h0);
    chk({30'h0, tx_pin, rx_bit}, 32'h3);
    for (int k = 0; k < 7; k++) begin
      {m, pat, msk, fid, ex} = flt(k);
      wb(1'b1, `CMB_OFS_CTRL, {30'h0, m});
      wb(1'b1, `CMB_OFS_PATTERN, pat);
      wb(1'b1, `CMB_OFS_MASK, msk);
      node.frame(fid, 8'h20);
      rd(`CMB_OFS_RXFLAG, {28'h0, ex});
      wb(1'b1, `CMB_OFS_RXFLAG, 32'h1);
    end
    wb(1'b1, `CMB_OFS_CTRL, 32'h0);
    wb(1'b1, `CMB_OFS_MASK, 32'hFFFF_FFFF);
    node.frame(32'h1111_0811, 8'h40);
    node.frame(32'h2222_0811, 8'h50);
    node.frame(32'h3333_0811, 8'h60);
    rd(`CMB_OFS_RXFLAG, 32'h3);
    rd(`CMB_OFS_FOREGROUND_RX_BUFFER, 32'h1111_0811);
    rd(`CMB_OFS_FOREGROUND_RX_BUFFER + 8'h8, 32'h4B4A_4948);
    wb(1'b1, `CMB_OFS_RXFLAG, 32'h3);
    rd(`CMB_OFS_RXFLAG, 32'h1);
    rd(`CMB_OFS_FOREGROUND_RX_BUFFER, 32'h2222_0811);
    wb(1'b1, `CMB_OFS_RXFLAG, 32'h1);
    rd(`CMB_OFS_RXFLAG, 32'h0);
    wb(1'b1, `CMB_OFS_TXBUF + 8'h10, 32'h0000_00A5);
    for (int b = 0; b < 3; b++)
      wb(1'b1, `CMB_OFS_TXBUF + 8'(16 * b) + 8'hC, {16'h0, 8'h30 - 8'(16 * b), 8'h0});
    wb(1'b1, `CMB_OFS_TXFLAG, 32'h7);
    wb(1'b1, `CMB_OFS_TXBUF + 8'h10, 32'hFFFF_FFFF);
    rd(`CMB_OFS_TXFLAG, 32'h0);
    chk({31'h0, tx_valid}, 32'h1);
    chk({30'h0, buf_sel}, 32'h2);
    wb(1'b1, `CMB_OFS_TXCTRL, 32'h4);
    wb(1'b0, `CMB_OFS_TXCTRL, 32'h0);
    chk(rdat & 32'h70, 32'h40);
    rd(`CMB_OFS_TXFLAG, 32'h4);
    chk({30'h0, buf_sel}, 32'h1);
    node.pulse(4'h8);
    repeat (2) @(posedge clk);
    chk({24'h0, rd_byte}, 32'hA5);
    chk({30'h0, ack_en, tx_valid}, 32'h0);
    rd_idx <= 4'hD;
    repeat (2) @(posedge clk);
    chk({24'h0, rd_byte}, 32'h20);
    node.frame(32'h7777_0811, 8'h0);
    rd(`CMB_OFS_RXFLAG, 32'h0);
    node.pulse(4'h4);
    rd(`CMB_OFS_TXFLAG, 32'h6);
    wb(1'b0, `CMB_OFS_TXCTRL, 32'h0);
    chk(rdat & 32'h70, 32'h40);
    wb(1'b1, `CMB_OFS_CTRL, 32'h4);
    wb(1'b1, `CMB_OFS_TXFLAG, 32'h2);
    chk({31'h0, loop_out}, 32'h1);
    node.pulse(4'h8);
    // error: buffer 1 must win the retry over buffer 0 again
    node.pulse(4'h2);
    chk({30'h0, buf_sel}, 32'h1);
    node.pulse(4'h8);
    node.frame(32'h7777_0811, 8'h0);
    rd(`CMB_OFS_RXFLAG, 32'h1);
    chk({31'h0, ack_en}, 32'h1);
    wb(1'b1, `CMB_OFS_RXFLAG, 32'h1);
    wb(1'b1, `CMB_OFS_CTRL, 32'h0);
    node.pulse(4'h1);
    node.frame(32'h5555_0811, 8'h0);
    rd(`CMB_OFS_RXFLAG, 32'h1);
    chk({30'h0, ack_en, tx_valid}, 32'h3);
    // let the idle level pass the receive sync chain
    repeat (4) @(posedge clk);
    chk({30'h0, tx_pin, rx_bit}, 32'h3);
    final_report();
  end
endmodule // cmb_core_tb
`default_nettype wire
